// ==== src/core_irq_and_pin_change_flags.sv ====
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - flags set regardless of the irq_control enable bits
// - timer0 overflow sets control bit 2
// - external pin event sets control bit 1
// - summary bit 0 set on pin change
// - summary read-only, clears with pin flags
// - falling edge enabled sets pin flags
// - disabled edge direction sets no flag
// - rise enable implements bit 3 only
// - unimplemented enable bits read zero
// - all six registers reset to zero
module core_irq_and_pin_change_flags #(
	parameter int SYNC_STAGES = 2
) (
	// clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        nrst_i,
	// register port
	input  wire logic [irq_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [irq_pkg::DATA_W-1:0]  reg_wdata_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	output logic      [irq_pkg::DATA_W-1:0]  reg_rdata_o,
	// event sources
	input  wire logic                        timer0_overflow_i,
	input  wire logic                        ext_pin_i,
	input  wire logic                        porte3_i,
	input  wire logic                        peripheral_irq_i,
	// interrupt outputs
	output logic                             core_irq_req_o,
	output logic                             irq_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// one address match used by every register write and the status read; read data decode by case
	function automatic logic hit(input logic [irq_pkg::ADDR_W-1:0] a,
			input logic [irq_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// state

	logic [SYNC_STAGES-1:0] ext_sync;
	logic [SYNC_STAGES-1:0] pe_sync;
	logic                   ext_prev;
	logic                   pe_prev;
	logic [7:3]             ctl_en;
	logic                   timer0_overflow_flag;
	logic                   ext_pin_irq_flag;
	logic                   porte3_rise_detect_enable;
	logic                   porte3_fall_detect_enable;
	logic                   pin_change_pin_flag;
	logic [2:0]             evt_status;
	logic [2:0]             evt_mask;
	logic                   pin_change_summary_flag;
	logic                   ext_now;
	logic                   pe_now;
	logic                   pe_rise;
	logic                   pe_fall;
	irq_pkg::evt_t          ev;
	logic                   wr_ctl;
	logic                   wr_pin;
	logic                   rd_status;
	logic                   next_core_irq;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only the last stage and the edge flop are read
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ext_sync <= '0;
			pe_sync  <= '0;
			ext_prev <= 1'b0;
			pe_prev  <= 1'b0;
		end else begin
			ext_sync <= {ext_sync[SYNC_STAGES-2:0], ext_pin_i};
			pe_sync  <= {pe_sync[SYNC_STAGES-2:0], porte3_i};
			ext_prev <= ext_sync[SYNC_STAGES-1];
			pe_prev  <= pe_sync[SYNC_STAGES-1];
		end
	end

	assign ext_now = ext_sync[SYNC_STAGES-1];
	assign pe_now  = pe_sync[SYNC_STAGES-1];

	// edge detection; a rising external pin is the external event
	assign pe_rise = pe_now & ~pe_prev;
	assign pe_fall = ~pe_now & pe_prev;

	assign ev.timer0     = timer0_overflow_i;
	assign ev.ext_pin    = ext_now & ~ext_prev;
	assign ev.pin_change = (pe_rise & porte3_rise_detect_enable)
		| (pe_fall & porte3_fall_detect_enable);
	// a disabled direction contributes nothing above

	////////////////////////////////////////////////////////////////////////
	// access decode
	assign wr_ctl    = reg_wr_i & hit(reg_addr_i, irq_pkg::OFS_IRQ_CONTROL);
	assign wr_pin    = reg_wr_i & hit(reg_addr_i, irq_pkg::OFS_PIN_FLAG);
	assign rd_status = reg_rd_i & hit(reg_addr_i, irq_pkg::OFS_EVT_STATUS);

	////////////////////////////////////////////////////////////////////////
	// enable bits of irq_control
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_en <= irq_pkg::RST_IRQ_CONTROL[7:3];
		end else if (wr_ctl) begin
			ctl_en <= reg_wdata_i[7:3];
		end
	end

	// flags ignore every enable; a set in the write cycle wins
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timer0_overflow_flag <= 1'b0;
			ext_pin_irq_flag     <= 1'b0;
		end else begin
			if (ev.timer0) begin
				timer0_overflow_flag <= 1'b1;
			end else if (wr_ctl) begin
				timer0_overflow_flag <=
					reg_wdata_i[irq_pkg::TIMER0_FLAG_BIT];
			end
			if (ev.ext_pin) begin
				ext_pin_irq_flag <= 1'b1;
			end else if (wr_ctl) begin
				ext_pin_irq_flag <=
					reg_wdata_i[irq_pkg::EXT_PIN_FLAG_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port e edge enables; only bit 3 has storage
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			porte3_rise_detect_enable <=
				irq_pkg::RST_EDGE_ENABLE[irq_pkg::PORTE_PIN_BIT];
			porte3_fall_detect_enable <=
				irq_pkg::RST_EDGE_ENABLE[irq_pkg::PORTE_PIN_BIT];
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, irq_pkg::OFS_RISE_ENABLE)) begin
				porte3_rise_detect_enable <=
					reg_wdata_i[irq_pkg::PORTE_PIN_BIT];
			end
			if (hit(reg_addr_i, irq_pkg::OFS_FALL_ENABLE)) begin
				porte3_fall_detect_enable <=
					reg_wdata_i[irq_pkg::PORTE_PIN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-pin change flag; software clears it, an edge in the same cycle wins
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_change_pin_flag <= 1'b0;
		end else if (ev.pin_change) begin
			pin_change_pin_flag <= 1'b1;
		end else if (wr_pin) begin
			pin_change_pin_flag <= reg_wdata_i[irq_pkg::PORTE_PIN_BIT];
		end
	end

	// summary has no storage, so irq_control writes cannot touch it
	assign pin_change_summary_flag = pin_change_pin_flag;

	////////////////////////////////////////////////////////////////////////
	// sticky event status, cleared by reading; new events survive the read
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			evt_status <= irq_pkg::RST_EVT;
		end else begin
			evt_status <= (rd_status ? irq_pkg::RST_EVT : evt_status) | ev;
		end
	end

	// event mask, same layout as the status
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			evt_mask <= irq_pkg::RST_EVT;
		end else if (reg_wr_i & hit(reg_addr_i, irq_pkg::OFS_EVT_MASK)) begin
			evt_mask <= reg_wdata_i[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core request; peripheral class also needs the peripheral enable
	assign next_core_irq = ctl_en[irq_pkg::GLOBAL_EN_BIT]
		& ((ctl_en[irq_pkg::TIMER0_EN_BIT] & timer0_overflow_flag)
		| (ctl_en[irq_pkg::EXT_PIN_EN_BIT] & ext_pin_irq_flag)
		| (ctl_en[irq_pkg::PIN_CHG_EN_BIT] & pin_change_summary_flag)
		| (ctl_en[irq_pkg::PERIPH_EN_BIT] & peripheral_irq_i));

	// both outputs registered to keep them glitch free
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			core_irq_req_o <= 1'b0;
			irq_o          <= 1'b0;
		end else begin
			core_irq_req_o <= next_core_irq;
			irq_o          <= |(evt_status & evt_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data: valid the cycle after the strobe only, zero otherwise
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= irq_pkg::RST_RDATA;
		end else begin
			reg_rdata_o <= irq_pkg::RST_RDATA;
			if (reg_rd_i) begin
				case (reg_addr_i)
					irq_pkg::OFS_IRQ_CONTROL: begin
						reg_rdata_o <= {ctl_en, timer0_overflow_flag,
							ext_pin_irq_flag,
							pin_change_summary_flag};
					end
					irq_pkg::OFS_RISE_ENABLE: begin
						reg_rdata_o[irq_pkg::PORTE_PIN_BIT] <=
							porte3_rise_detect_enable;
					end
					irq_pkg::OFS_FALL_ENABLE: begin
						reg_rdata_o[irq_pkg::PORTE_PIN_BIT] <=
							porte3_fall_detect_enable;
					end
					irq_pkg::OFS_PIN_FLAG: begin
						reg_rdata_o[irq_pkg::PORTE_PIN_BIT] <=
							pin_change_pin_flag;
					end
					irq_pkg::OFS_EVT_STATUS: begin
						reg_rdata_o[2:0] <= evt_status;
					end
					irq_pkg::OFS_EVT_MASK: begin
						reg_rdata_o[2:0] <= evt_mask;
					end
					default: begin
						reg_rdata_o <= irq_pkg::RST_RDATA;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	property p_timer0_flag;
		timer0_overflow_i |=> timer0_overflow_flag;
	endproperty
	a_timer0_flag: assert property (p_timer0_flag)
		else $error("timer0 overflow did not set its flag");

	property p_ext_flag;
		$rose(ext_now) |=> ext_pin_irq_flag;
	endproperty
	a_ext_flag: assert property (p_ext_flag)
		else $error("external pin edge did not set its flag");

	property p_summary_ro;
		wr_ctl && reg_wdata_i[0] && !pin_change_pin_flag && !ev.pin_change
			|=> !pin_change_summary_flag;
	endproperty
	a_summary_ro: assert property (p_summary_ro)
		else $error("summary flag changed by a write");

	property p_fall_sets;
		porte3_fall_detect_enable && $fell(pe_now)
			|=> pin_change_pin_flag;
	endproperty
	a_fall_sets: assert property (p_fall_sets)
		else $error("enabled falling edge did not set pin flag");

	property p_rise_sets;
		porte3_rise_detect_enable && $rose(pe_now)
			|=> pin_change_summary_flag;
	endproperty
	a_rise_sets: assert property (p_rise_sets)
		else $error("enabled rising edge did not set summary");

	property p_disabled_quiet;
		!porte3_rise_detect_enable && !porte3_fall_detect_enable
			&& !pin_change_pin_flag && !wr_pin |=> !pin_change_pin_flag;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("pin flag set with both edges disabled");

	property p_unimpl_zero;
		reg_rd_i && (hit(reg_addr_i, irq_pkg::OFS_RISE_ENABLE)
			|| hit(reg_addr_i, irq_pkg::OFS_FALL_ENABLE))
			|=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[2:0] == 3'h0;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero)
		else $error("unimplemented enable bits read nonzero");

	property p_reset_zero;
		$rose(nrst_i) |-> ctl_en == 5'h00 && !timer0_overflow_flag
			&& !ext_pin_irq_flag && !porte3_rise_detect_enable
			&& !porte3_fall_detect_enable;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("registers not zero after reset");

	property p_global_gate;
		!ctl_en[irq_pkg::GLOBAL_EN_BIT] |=> !core_irq_req_o;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("core request without global enable");

	property p_flag_no_enable;
		ctl_en == 5'h00 && timer0_overflow_i |=> timer0_overflow_flag;
	endproperty
	a_flag_no_enable: assert property (p_flag_no_enable)
		else $error("flag not set while enables were off");

	// any enabled edge must show up in the summary on the next cycle
	property p_summary_set;
		ev.pin_change |=> pin_change_summary_flag;
	endproperty
	a_summary_set: assert property (p_summary_set)
		else $error("pin change did not set the summary flag");

	c_rise_event: cover property (porte3_rise_detect_enable
		&& $rose(pe_now));

	c_core_req: cover property ($rose(core_irq_req_o));
	c_fall_event: cover property (porte3_fall_detect_enable
		&& $fell(pe_now));
	c_status_read: cover property (rd_status && evt_status != 3'h0);

endmodule : core_irq_and_pin_change_flags

`default_nettype wire

// ==== src/irq_pkg.sv ====
package irq_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL  = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_RISE_ENABLE  = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_FALL_ENABLE  = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_PIN_FLAG     = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_EVT_STATUS   = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK     = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// irq_control field positions
	localparam int GLOBAL_EN_BIT    = 7;
	localparam int PERIPH_EN_BIT    = 6;
	localparam int TIMER0_EN_BIT    = 5;
	localparam int EXT_PIN_EN_BIT   = 4;
	localparam int PIN_CHG_EN_BIT   = 3;
	localparam int TIMER0_FLAG_BIT  = 2;
	localparam int EXT_PIN_FLAG_BIT = 1;
	localparam int SUMMARY_FLAG_BIT = 0;

	// the one implemented port e bit in edge enables and pin flags
	localparam int PORTE_PIN_BIT = 3;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [DATA_W-1:0] RST_IRQ_CONTROL = 8'h00;
	localparam logic [DATA_W-1:0] RST_EDGE_ENABLE = 8'h00;
	localparam logic [2:0]        RST_EVT         = 3'h0;
	localparam logic [DATA_W-1:0] RST_RDATA       = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// event bundle, bit order matches the status and mask registers
	typedef struct packed {
		logic timer0;
		logic ext_pin;
		logic pin_change;
	} evt_t;

endpackage : irq_pkg

// ==== verif/core_irq_and_pin_change_flags_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module core_irq_and_pin_change_flags_tb;

	localparam logic [2:0] CTL  = irq_pkg::OFS_IRQ_CONTROL;
	localparam logic [2:0] RISE = irq_pkg::OFS_RISE_ENABLE;
	localparam logic [2:0] FALL = irq_pkg::OFS_FALL_ENABLE;
	localparam logic [2:0] PFLG = irq_pkg::OFS_PIN_FLAG;
	localparam logic [2:0] STAT = irq_pkg::OFS_EVT_STATUS;
	localparam logic [2:0] MASK = irq_pkg::OFS_EVT_MASK;

	logic       sys_clk_i;
	logic       nrst_i;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic       reg_wr_i;
	logic       reg_rd_i;
	logic [7:0] reg_rdata_o;
	logic       tmr_ovf;
	logic       ext_pin;
	logic       porte3;
	logic       periph_req;
	logic       core_irq_req_o;
	logic       irq_o;
	int         mismatches;
	int         num_checks;

	core_irq_and_pin_change_flags i_core_irq_and_pin_change_flags (
		.sys_clk_i        (sys_clk_i),
		.nrst_i           (nrst_i),
		.reg_addr_i       (reg_addr_i),
		.reg_wdata_i      (reg_wdata_i),
		.reg_wr_i         (reg_wr_i),
		.reg_rd_i         (reg_rd_i),
		.reg_rdata_o      (reg_rdata_o),
		.timer0_overflow_i(tmr_ovf),
		.ext_pin_i        (ext_pin),
		.porte3_i         (porte3),
		.peripheral_irq_i (periph_req),
		.core_irq_req_o   (core_irq_req_o),
		.irq_o            (irq_o)
	);

	irq_event_sources i_irq_event_sources (
		.sys_clk_i        (sys_clk_i),
		.timer0_overflow_o(tmr_ovf),
		.ext_pin_o        (ext_pin),
		.porte3_o         (porte3),
		.periph_req_o     (periph_req)
	);

	////////////////////////////////////////////////////////////////////////////
	// 40 mhz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe, so look mid-cycle
	task automatic rd(input logic [2:0] a, input logic [7:0] exp,
		input string nm);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		chk(nm, exp, reg_rdata_o);
	endtask : rd

	// pin events need sync and edge flops before the flag lands
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask : idle

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// watchdog in case a task never returns
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		mismatches++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		nrst_i = 1'b0;
		reg_addr_i = 3'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		for (int a = 0; a < 7; a++) rd(a[2:0], 8'h00, "reset");
		$display("test reset done");
		wr(RISE, 8'hff);
		rd(RISE, 8'h08, "rise");
		wr(FALL, 8'hff);
		rd(FALL, 8'h08, "fall");
		wr(RISE, 8'h00);
		wr(FALL, 8'h00);
		wr(3'h6, 8'hff);
		rd(3'h6, 8'h00, "unmapped");
		wr(CTL, 8'h01);
		rd(CTL, 8'h00, "summary write");
		$display("test access done");
		i_irq_event_sources.pulse_timer0();
		idle(4);
		rd(CTL, 8'h04, "timer flag");
		chk("req", 8'h00, {7'h00, core_irq_req_o});
		rd(STAT, 8'h04, "status");
		rd(STAT, 8'h00, "status clr");
		wr(CTL, 8'h00);
		i_irq_event_sources.set_pins(1'b1, 1'b0, 1'b0);
		idle(6);
		rd(CTL, 8'h02, "ext flag");
		wr(CTL, 8'h00);
		i_irq_event_sources.set_pins(1'b0, 1'b1, 1'b0);
		idle(6);
		i_irq_event_sources.set_pins(1'b0, 1'b0, 1'b0);
		idle(6);
		rd(CTL, 8'h00, "pins off");
		$display("test flags done");
		wr(RISE, 8'h08);
		i_irq_event_sources.set_pins(1'b0, 1'b1, 1'b0);
		idle(6);
		rd(CTL, 8'h01, "rise summary");
		rd(PFLG, 8'h08, "rise pin");
		wr(CTL, 8'h00);
		rd(CTL, 8'h01, "summary kept");
		wr(PFLG, 8'h00);
		rd(CTL, 8'h00, "summary clr");
		i_irq_event_sources.set_pins(1'b0, 1'b0, 1'b0);
		idle(6);
		rd(PFLG, 8'h00, "fall off");
		wr(RISE, 8'h00);
		wr(FALL, 8'h08);
		i_irq_event_sources.set_pins(1'b0, 1'b1, 1'b0);
		idle(6);
		rd(PFLG, 8'h00, "rise off");
		i_irq_event_sources.set_pins(1'b0, 1'b0, 1'b0);
		idle(6);
		rd(PFLG, 8'h08, "fall pin");
		rd(CTL, 8'h01, "fall summary");
		rd(STAT, 8'h03, "status acc");
		$display("test pin change done");
		wr(PFLG, 8'h00);
		wr(CTL, 8'h00);
		wr(MASK, 8'h04);
		wr(CTL, 8'ha0);
		i_irq_event_sources.pulse_timer0();
		idle(4);
		chk("req on", 8'h01, {7'h00, core_irq_req_o});
		chk("irq on", 8'h01, {7'h00, irq_o});
		rd(STAT, 8'h04, "status irq");
		idle(2);
		chk("irq off", 8'h00, {7'h00, irq_o});
		wr(CTL, 8'h84);
		idle(2);
		chk("req noen", 8'h00, {7'h00, core_irq_req_o});
		wr(CTL, 8'hc0);
		i_irq_event_sources.set_pins(1'b0, 1'b0, 1'b1);
		idle(4);
		chk("req per", 8'h01, {7'h00, core_irq_req_o});
		wr(CTL, 8'h80);
		idle(2);
		chk("req noper", 8'h00, {7'h00, core_irq_req_o});
		i_irq_event_sources.set_pins(1'b0, 1'b0, 1'b0);
		wr(PFLG, 8'h08);
		wr(CTL, 8'h88);
		idle(2);
		chk("req pin", 8'h01, {7'h00, core_irq_req_o});
		wr(CTL, 8'h92);
		idle(2);
		chk("req ext", 8'h01, {7'h00, core_irq_req_o});
		$display("test interrupt done");
		// a second reset in mid-run must clear the live state again
		wr(RISE, 8'h08);
		wr(MASK, 8'h07);
		@(posedge sys_clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00, "rerun");
		chk("req rerun", 8'h00, {7'h00, core_irq_req_o});
		chk("irq rerun", 8'h00, {7'h00, irq_o});
		$display("test reset rerun done");
		end_sim();
	end

endmodule : core_irq_and_pin_change_flags_tb

`default_nettype wire

// ==== verif/irq_event_sources.sv ====
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// stand-in for the overflowing timer, the external pin, the port e pin and
// the peripheral request; every line is always driven to a defined level
module irq_event_sources (
	// clock
	input  wire logic sys_clk_i,
	// event lines into the block
	output var logic  timer0_overflow_o,
	output var logic  ext_pin_o,
	output var logic  porte3_o,
	output var logic  periph_req_o
);

	// quiet levels from time zero so no false edge is seen after reset
	initial begin
		timer0_overflow_o = 1'b0;
		ext_pin_o = 1'b0;
		porte3_o = 1'b0;
		periph_req_o = 1'b0;
	end

	// a same-clock timer overflows for exactly one cycle
	task automatic pulse_timer0();
		@(posedge sys_clk_i);
		timer0_overflow_o <= 1'b1;
		@(posedge sys_clk_i);
		timer0_overflow_o <= 1'b0;
	endtask : pulse_timer0

	// pins move just after an edge, as any outside source might
	task automatic set_pins(input logic ext, input logic pe3, input logic per);
		@(posedge sys_clk_i);
		ext_pin_o <= ext;
		porte3_o <= pe3;
		periph_req_o <= per;
	endtask : set_pins

endmodule : irq_event_sources

`default_nettype wire
